// ---- sfpe_map.svh ----
/*
 * Named constants for the serial flash program and erase block: opcodes,
 * frame lengths, address fields, erase sizes and cycle times.
 * Assumes it is included by its bare name from files that need it.
 */
`ifndef SFPE_MAP_SVH
`define SFPE_MAP_SVH

`define SFPE_OP_LATCH_SET 8'h06
`define SFPE_OP_PAGE_PROG 8'h02
`define SFPE_OP_QUAD_PROG 8'h32
`define SFPE_OP_SECTOR_ERASE 8'h20
`define SFPE_OP_BLK32_ERASE 8'h52
`define SFPE_OP_BLK64_ERASE 8'hD8

`define SFPE_OPCODE_EDGES 6'h08
`define SFPE_HEADER_EDGES 6'h20
`define SFPE_FIRST_EDGE 6'h00
`define SFPE_SINGLE_STEP 3'h1
`define SFPE_QUAD_STEP 3'h4
`define SFPE_BYTE_DONE 3'h0

`define SFPE_ADDR_PAGE 23:8
`define SFPE_ADDR_COL 7:0
`define SFPE_ADDR_BLK 23:16
`define SFPE_ADDR_ONES 24'hFFFFFF
`define SFPE_LAST_COL 8'hFF
`define SFPE_PROT_SHIFT 3
`define SFPE_PROT_TOP 9'h100
`define SFPE_PROT_NONE 5'h00

`define SFPE_SECTOR_BITS 12
`define SFPE_BLK32_BITS 15
`define SFPE_BLK64_BITS 16

`define SFPE_CLK_PERIOD_NS 50
`define SFPE_PROG_TIME_NS 500000
`define SFPE_ERASE_TIME_NS 2000000

`endif

// ---- sfpe_pkg.sv ----
/*
 * Types shared by the serial flash program and erase block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sfpe_pkg;

    typedef enum {SFPE_IDLE, SFPE_WALK, SFPE_BUSY} sfpe_state_t;

    typedef enum logic [1:0] {SFPE_ER_SECTOR, SFPE_ER_BLK32, SFPE_ER_BLK64} sfpe_erase_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [5:0] hdr_cnt;
        logic data_seen;
        logic aligned;
    } sfpe_frame_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] data;
    } sfpe_prog_t;

    typedef struct packed {
        logic [23:0] base;
        sfpe_erase_t size;
    } sfpe_erase_req_t;

endpackage

// ---- sfpe_sync2.sv ----
/*
 * Two flip-flop level synchroniser, W bits wide.
 * Assumes each bit is a level that changes seldom compared with clk.
 */
`timescale 1ns/1ps
module sfpe_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule // sfpe_sync2

// ---- sfpe_page_buf.sv ----
/*
 * Page buffer: one byte and one valid bit per column, written on the
 * serial clock and read by the system clock once the frame has ended.
 * Assumes the writer is quiet while the reader walks the buffer.
 */
`timescale 1ns/1ps
module sfpe_page_buf #(
    parameter int DEPTH = 256,
    parameter int W = 8,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic wr_clk,
    input wire logic clr,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_idx,
    output logic [W-1:0] rd_data,
    output logic rd_valid
);
    logic [W-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] valid_q;

    always_ff @(posedge wr_clk)
    begin
        if (wr_en)
        begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // A later byte for the same column replaces the earlier one.
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_valid
        always_ff @(posedge wr_clk)
        begin
            if (clr)
            begin
                valid_q[i] <= 1'b0;
            end
            else if (wr_en && wr_idx == AW'(i))
            begin
                valid_q[i] <= 1'b1;
            end
        end
    end

    assign rd_data = mem_q[rd_idx];
    assign rd_valid = valid_q[rd_idx];
endmodule // sfpe_page_buf

// ---- sfpe_flash_pe.sv ----
/*
 * Program and erase command engine of a serial NOR flash: shifts in
 * opcode, address and data on the serial clock, then checks and runs the
 * self-timed program or erase cycle on the system clock.
 * Assumes the host keeps sclk still while cs_n is high and keeps cs_n high
 * for at least four clk periods between frames.
 */
`timescale 1ns/1ps
`include "sfpe_map.svh"
module sfpe_flash_pe #(
    parameter int unsigned PROG_TIME_NS = `SFPE_PROG_TIME_NS,
    parameter int unsigned ERASE_TIME_NS = `SFPE_ERASE_TIME_NS,
    parameter int PAGE_BYTES = 256
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] quad_data_lines,
    input wire logic quad_enable_bit,
    input wire logic [4:0] block_protect_bits,
    output logic write_in_progress,
    output logic write_enable_latch,
    output logic prog_wr_valid,
    output sfpe_pkg::sfpe_prog_t prog_wr,
    output logic erase_valid,
    output sfpe_pkg::sfpe_erase_req_t erase_req
);
    localparam int unsigned CLK_NS = `SFPE_CLK_PERIOD_NS;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ERASE_CYCLES = (ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int CW = $clog2(PAGE_BYTES);

    // Link side, clocked by the host's serial clock.
    sfpe_pkg::sfpe_frame_t fr_q;
    logic [5:0] hdr_cnt_q;
    logic [2:0] bit_cnt_q;
    logic [CW-1:0] byte_idx_q;
    logic data_seen_q;
    logic [7:0] dsh_q;
    logic frame_tog_q;
    logic busy_s;
    logic in_hdr;
    logic quad_data;
    logic [2:0] bit_nx;
    logic [7:0] dsh_d;
    logic byte_done;
    logic fr_is_prog;
    logic buf_wr;
    logic buf_clr;
    logic [CW-1:0] buf_col;

    assign in_hdr = (hdr_cnt_q != `SFPE_HEADER_EDGES);
    assign quad_data = (fr_q.opcode == `SFPE_OP_QUAD_PROG);
    assign bit_nx = bit_cnt_q + (quad_data ? `SFPE_QUAD_STEP : `SFPE_SINGLE_STEP);
    assign dsh_d = quad_data ? {dsh_q[3:0], quad_data_lines} : {dsh_q[6:0], quad_data_lines[0]};
    assign byte_done = !in_hdr && (bit_nx == `SFPE_BYTE_DONE);
    assign fr_is_prog = (fr_q.opcode == `SFPE_OP_PAGE_PROG) || quad_data;

    // Frame counters restart whenever the host deselects the device.
    // Rising edge sampling.
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            hdr_cnt_q <= `SFPE_FIRST_EDGE;
            bit_cnt_q <= `SFPE_BYTE_DONE;
            byte_idx_q <= '0;
            data_seen_q <= 1'b0;
        end
        else if (in_hdr)
        begin
            hdr_cnt_q <= hdr_cnt_q + 6'h01;
        end
        else
        begin
            bit_cnt_q <= bit_nx;
            if (byte_done)
            begin
                byte_idx_q <= byte_idx_q + CW'(1);
                data_seen_q <= 1'b1;
            end
        end
    end

    // The frame record is left standing when sclk stops; the clk side reads it after cs_n rises.
    // Address high byte first.
    always_ff @(posedge sclk)
    begin
        if (hdr_cnt_q < `SFPE_OPCODE_EDGES)
        begin
            fr_q.opcode <= {fr_q.opcode[6:0], quad_data_lines[0]};
        end
        else if (in_hdr)
        begin
            fr_q.addr <= {fr_q.addr[22:0], quad_data_lines[0]};
        end
        fr_q.hdr_cnt <= in_hdr ? hdr_cnt_q + 6'h01 : hdr_cnt_q;
        fr_q.aligned <= in_hdr ? 1'b1 : byte_done;
        fr_q.data_seen <= in_hdr ? 1'b0 : (data_seen_q || byte_done);
    end

    always_ff @(posedge sclk)
    begin
        if (!in_hdr)
        begin
            dsh_q <= dsh_d;
        end
    end

    // Marks that a frame with at least one edge took place.
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            frame_tog_q <= 1'b0;
        end
        else if (hdr_cnt_q == `SFPE_FIRST_EDGE)
        begin
            frame_tog_q <= ~frame_tog_q;
        end
    end

    sfpe_sync2 #(
        .W(1)
    ) u_busy_sync (
        .clk(sclk),
        .d(write_in_progress),
        .q(busy_s)
    );

    assign buf_col = fr_q.addr[`SFPE_ADDR_COL] + byte_idx_q;
    assign buf_wr = byte_done && fr_is_prog && !busy_s;
    assign buf_clr = (hdr_cnt_q == `SFPE_FIRST_EDGE) && !cs_n && !busy_s;

    logic [CW-1:0] walk_idx_q;
    logic [7:0] rd_data;
    logic rd_valid;

    sfpe_page_buf #(
        .DEPTH(PAGE_BYTES),
        .W(8),
        .AW(CW)
    ) u_page_buf (
        .wr_clk(sclk),
        .clr(buf_clr),
        .wr_en(buf_wr),
        .wr_idx(buf_col),
        .wr_data(dsh_d),
        .rd_idx(walk_idx_q),
        .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    // System side.
    logic cs_s;
    logic tog_s;
    logic cs_prev_q;
    logic seen_q;
    logic new_frame;

    sfpe_sync2 #(
        .W(2)
    ) u_link_sync (
        .clk(clk),
        .d({cs_n, frame_tog_q}),
        .q({cs_s, tog_s})
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cs_prev_q <= 1'b1;
            seen_q <= 1'b0;
        end
        else
        begin
            cs_prev_q <= cs_s;
            if (cs_s && !cs_prev_q)
            begin
                seen_q <= tog_s;
            end
        end
    end

    assign new_frame = cs_s && !cs_prev_q && (tog_s != seen_q);

    logic op_latch;
    logic op_prog;
    logic op_erase;
    logic shape_op_only;
    logic shape_prog;
    logic shape_erase;
    logic protected_hit;
    logic prog_go;
    logic erase_go;
    sfpe_pkg::sfpe_erase_t erase_kind;
    logic [23:0] erase_mask;

    assign op_latch = (fr_q.opcode == `SFPE_OP_LATCH_SET);
    assign op_prog = (fr_q.opcode == `SFPE_OP_PAGE_PROG)
        || ((fr_q.opcode == `SFPE_OP_QUAD_PROG) && quad_enable_bit);
    assign op_erase = (fr_q.opcode == `SFPE_OP_SECTOR_ERASE) || (fr_q.opcode == `SFPE_OP_BLK32_ERASE)
        || (fr_q.opcode == `SFPE_OP_BLK64_ERASE);
    assign shape_op_only = (fr_q.hdr_cnt == `SFPE_OPCODE_EDGES);
    assign shape_prog = (fr_q.hdr_cnt == `SFPE_HEADER_EDGES) && fr_q.data_seen && fr_q.aligned;
    assign shape_erase = (fr_q.hdr_cnt == `SFPE_HEADER_EDGES) && !fr_q.data_seen && fr_q.aligned;
    assign protected_hit = (block_protect_bits != `SFPE_PROT_NONE) && ({1'b0, fr_q.addr[`SFPE_ADDR_BLK]}
        >= (`SFPE_PROT_TOP - (9'(block_protect_bits) << `SFPE_PROT_SHIFT)));
    assign prog_go = new_frame && !write_in_progress && write_enable_latch && op_prog && shape_prog
        && !protected_hit;
    assign erase_go = new_frame && !write_in_progress && write_enable_latch && op_erase && shape_erase
        && !protected_hit;

    always_comb
    begin
        if (fr_q.opcode == `SFPE_OP_BLK64_ERASE)
        begin
            erase_kind = sfpe_pkg::SFPE_ER_BLK64;
            erase_mask = `SFPE_ADDR_ONES << `SFPE_BLK64_BITS;
        end
        else if (fr_q.opcode == `SFPE_OP_BLK32_ERASE)
        begin
            erase_kind = sfpe_pkg::SFPE_ER_BLK32;
            erase_mask = `SFPE_ADDR_ONES << `SFPE_BLK32_BITS;
        end
        else
        begin
            erase_kind = sfpe_pkg::SFPE_ER_SECTOR;
            erase_mask = `SFPE_ADDR_ONES << `SFPE_SECTOR_BITS;
        end
    end

    sfpe_pkg::sfpe_state_t state_q;
    logic [31:0] tmr_q;
    logic [15:0] page_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= sfpe_pkg::SFPE_IDLE;
            tmr_q <= '0;
            walk_idx_q <= '0;
            page_q <= '0;
        end
        else
        begin
            unique case (state_q)
                sfpe_pkg::SFPE_IDLE:
                begin
                    walk_idx_q <= '0;
                    if (prog_go)
                    begin
                        state_q <= sfpe_pkg::SFPE_WALK;
                        tmr_q <= 32'(PROG_CYCLES);
                        page_q <= fr_q.addr[`SFPE_ADDR_PAGE];
                    end
                    else if (erase_go)
                    begin
                        state_q <= sfpe_pkg::SFPE_BUSY;
                        tmr_q <= 32'(ERASE_CYCLES);
                    end
                end
                sfpe_pkg::SFPE_WALK:
                begin
                    walk_idx_q <= walk_idx_q + CW'(1);
                    if (tmr_q != '0)
                    begin
                        tmr_q <= tmr_q - 32'h00000001;
                    end
                    if (walk_idx_q == CW'(PAGE_BYTES - 1))
                    begin
                        state_q <= sfpe_pkg::SFPE_BUSY;
                    end
                end
                sfpe_pkg::SFPE_BUSY:
                begin
                    if (tmr_q <= 32'h00000001)
                    begin
                        state_q <= sfpe_pkg::SFPE_IDLE;
                        tmr_q <= '0;
                    end
                    else
                    begin
                        tmr_q <= tmr_q - 32'h00000001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            write_in_progress <= 1'b0;
        end
        else if (prog_go || erase_go)
        begin
            write_in_progress <= 1'b1;
        end
        else if (state_q == sfpe_pkg::SFPE_BUSY && tmr_q <= 32'h00000001)
        begin
            write_in_progress <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            write_enable_latch <= 1'b0;
        end
        else if (prog_go || erase_go)
        begin
            write_enable_latch <= 1'b0;
        end
        else if (new_frame && !write_in_progress && op_latch && shape_op_only)
        begin
            write_enable_latch <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prog_wr_valid <= 1'b0;
            prog_wr <= '0;
            erase_valid <= 1'b0;
            erase_req <= '0;
        end
        else
        begin
            prog_wr_valid <= (state_q == sfpe_pkg::SFPE_WALK) && rd_valid;
            if (state_q == sfpe_pkg::SFPE_WALK && rd_valid)
            begin
                prog_wr.addr <= {page_q, walk_idx_q};
                prog_wr.data <= rd_data;
            end
            erase_valid <= erase_go;
            if (erase_go)
            begin
                erase_req.base <= fr_q.addr & erase_mask;
                erase_req.size <= erase_kind;
            end
        end
    end

    // Checking logic.
    logic [31:0] run_len_q;
    logic last_prog_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            run_len_q <= '0;
            last_prog_q <= 1'b0;
        end
        else
        begin
            run_len_q <= write_in_progress ? run_len_q + 32'h00000001 : 32'h00000000;
            if (prog_go || erase_go)
            begin
                last_prog_q <= prog_go;
            end
        end
    end

    chk_latch_needed: assert property (@(posedge clk) disable iff (rst)
        $rose(write_in_progress) |-> $past(write_enable_latch))
        else $error("Cycle started without write enable latch.");

    chk_latch_cleared: assert property (@(posedge clk) disable iff (rst)
        $rose(write_in_progress) |-> !write_enable_latch ##1 !write_enable_latch)
        else $error("Write enable latch still set in cycle.");

    chk_quad_gate: assert property (@(posedge clk) disable iff (rst)
        prog_go && (fr_q.opcode == `SFPE_OP_QUAD_PROG) |-> quad_enable_bit)
        else $error("Quad program accepted without quad enable.");

    chk_protect_block: assert property (@(posedge clk) disable iff (rst)
        new_frame && protected_hit && !write_in_progress |=> !write_in_progress ##1 !erase_valid)
        else $error("Protected target started a cycle.");

    chk_busy_refuse: assert property (@(posedge clk) disable iff (rst)
        new_frame && write_in_progress |=> !erase_valid && $stable(page_q))
        else $error("Command taken while busy.");

    chk_erase_shape: assert property (@(posedge clk) disable iff (rst)
        erase_valid |-> $past(shape_erase) && $past(new_frame))
        else $error("Erase issued on a bad frame.");

    chk_prog_time: assert property (@(posedge clk) disable iff (rst)
        $fell(write_in_progress) && last_prog_q |-> run_len_q == PROG_CYCLES)
        else $error("Program cycle length wrong.");

    chk_erase_time: assert property (@(posedge clk) disable iff (rst)
        $fell(write_in_progress) && !last_prog_q |-> run_len_q == ERASE_CYCLES)
        else $error("Erase cycle length wrong.");

    chk_page_wrap: assert property (@(posedge clk) disable iff (rst)
        prog_wr_valid |-> prog_wr.addr[`SFPE_ADDR_PAGE] == page_q && write_in_progress)
        else $error("Program write left its page.");

    chk_sector_base: assert property (@(posedge clk) disable iff (rst)
        erase_valid |-> (erase_req.base & ~(`SFPE_ADDR_ONES << `SFPE_SECTOR_BITS)) == 24'h000000)
        else $error("Erase base not sector aligned.");
endmodule // sfpe_flash_pe

// ---- sfpe_host_model.sv ----
/* Host model of the serial bus: frames commands on select, serial clock and data lines.
   Assumes one caller at a time; the serial clock stands low between frames. */
`timescale 1ns/1ps
module sfpe_host_model (
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io
);
    logic [7:0] dat [300];

    // Select rises after time zero so that the device's frame counters see a real clearing edge.
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b0;
        io = 4'h5;
        #5 cs_n = 1'b1;
    end

    task automatic put(input logic [3:0] v);
        io = v;
        #15 sclk = 1'b1;
        #15 sclk = 1'b0;
    endtask

    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nb, input bit q, input int ex);
        logic [31:0] h;
        h = {op, a};
        cs_n = 1'b0;
        #20;
        for (int i = 31; i >= ((op == 8'h06) ? 24 : 0); i--)
            put({~io[3:1], h[i]});
        for (int b = 0; b < nb; b++)
            if (q)
            begin
                put(dat[b][7:4]);
                put(dat[b][3:0]);
            end
            else
                for (int i = 7; i >= 0; i--)
                    put({~io[3:1], dat[b][i]});
        repeat (ex) put(~io);
        #20 cs_n = 1'b1;
        io = ~io;
    endtask
endmodule // sfpe_host_model

// ---- serial_flash_program_erase_tb.sv ----
/* Self-checking bench for the program and erase engine.
   Assumes the package and the host model are compiled first. */
`timescale 1ns/1ps
module serial_flash_program_erase_tb;
    localparam int T_NS = 20000;
    localparam int CYC = T_NS / 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic qen = 1'b0;
    logic [4:0] bp = 5'h00;
    logic sclk, cs_n, busy, latch, pv, ev;
    logic [3:0] io;
    logic [23:0] a;
    sfpe_pkg::sfpe_prog_t pw;
    sfpe_pkg::sfpe_erase_req_t er;
    sfpe_pkg::sfpe_prog_t pq[$];
    sfpe_pkg::sfpe_erase_req_t eq[$];
    logic [7:0] ops [4] = '{8'h20, 8'h52, 8'hD8, 8'h02};
    logic [23:0] msk [3] = '{24'h000FFF, 24'h007FFF, 24'h00FFFF};
    int miscompares = 0;
    int n_tests = 0;

    always #25 clk = ~clk;

    sfpe_host_model sfpe_host_model_inst (.sclk(sclk), .cs_n(cs_n), .io(io));
    sfpe_flash_pe #(.PROG_TIME_NS(T_NS), .ERASE_TIME_NS(T_NS)) sfpe_flash_pe_inst (.clk(clk), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .quad_data_lines(io), .quad_enable_bit(qen), .block_protect_bits(bp),
        .write_in_progress(busy), .write_enable_latch(latch), .prog_wr_valid(pv), .prog_wr(pw),
        .erase_valid(ev), .erase_req(er));

    task automatic fail(input string m);
        miscompares++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic cmp_bit(input logic g, input logic e, input string m);
        n_tests++;
        if (g !== e)
            fail(m);
    endtask

    task automatic cmp_prog(input sfpe_pkg::sfpe_prog_t g, input sfpe_pkg::sfpe_prog_t e);
        n_tests++;
        if (g !== e)
            fail("program write differs");
    endtask

    task automatic cmp_erase(input sfpe_pkg::sfpe_erase_req_t g, input sfpe_pkg::sfpe_erase_req_t e);
        n_tests++;
        if (g !== e)
            fail("erase request differs");
    endtask

    task automatic wrap_up;
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask

    task automatic write_latch_set_cmd(input logic e);
        sfpe_host_model_inst.frame(8'h06, 24'h000000, 0, 1'b0, 0);
        tick(8);
        cmp_bit(latch, e, "latch after set command");
    endtask

    // Later bytes on the same column replace earlier ones; writes leave in column order.
    task automatic expect_prog(input logic [23:0] ad, input int nb);
        logic [7:0] v [256];
        bit h [256] = '{default: 1'b0};
        logic [7:0] k;
        for (int b = 0; b < nb; b++)
        begin
            k = ad[7:0] + 8'(b);
            v[k] = sfpe_host_model_inst.dat[b];
            h[k] = 1'b1;
        end
        for (int c = 0; c < 256; c++)
            if (h[c])
                pq.push_back({ad[23:8], 8'(c), v[c]});
    endtask

    task automatic run(input logic [7:0] op, input logic [23:0] ad, input int nb, input bit q, input int ex,
        input logic ok);
        int n;
        n = 0;
        sfpe_host_model_inst.frame(op, ad, nb, q, ex);
        while (busy !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        cmp_bit(busy, ok, "busy after command");
        if (ok === 1'b1 && busy !== 1'b1)
            wrap_up;
        else if (busy === 1'b1)
        begin
            cmp_bit(latch, 1'b0, "latch during cycle");
            n = 0;
            while (busy === 1'b1 && n < 2 * CYC)
            begin
                tick(1);
                n++;
            end
            cmp_bit(n == CYC, 1'b1, "cycle length");
            if (n >= 2 * CYC)
                wrap_up;
        end
    endtask

    always @(negedge clk)
    begin
        if (pv === 1'b1)
            if (pq.size() == 0)
                fail("unexpected program write");
            else
                cmp_prog(pw, pq.pop_front());
        if (ev === 1'b1)
            if (eq.size() == 0)
                fail("unexpected erase request");
            else
                cmp_erase(er, eq.pop_front());
    end

    initial
    begin
        void'($urandom(32'h669B));
        for (int b = 0; b < 300; b++)
            sfpe_host_model_inst.dat[b] = 8'($urandom);
        tick(12);
        rst = 1'b0;
        tick(2);
        run(8'h02, 24'h001000, 4, 1'b0, 0, 1'b0);
        write_latch_set_cmd(1'b1);
        run(8'h32, 24'h002000, 2, 1'b1, 0, 1'b0);
        run(8'h02, 24'h000200, 2, 1'b0, 3, 1'b0);
        expect_prog(24'h0123FE, 3);
        run(8'h02, 24'h0123FE, 3, 1'b0, 0, 1'b1);
        write_latch_set_cmd(1'b1);
        qen = 1'b1;
        expect_prog(24'h045610, 258);
        run(8'h32, 24'h045610, 258, 1'b1, 0, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            write_latch_set_cmd(1'b1);
            a = 24'($urandom) & 24'h7FFFFF;
            eq.push_back({a & ~msk[k], 2'(k)});
            run(ops[k], a, 0, 1'b0, 0, 1'b1);
        end
        write_latch_set_cmd(1'b1);
        run(8'h20, 24'h003000, 1, 1'b0, 0, 1'b0);
        bp = 5'h01;
        for (int k = 0; k < 4; k++)
            run(ops[k], 24'hFC1234, (k == 3) ? 1 : 0, 1'b0, 0, 1'b0);
        bp = 5'h00;
        eq.push_back({24'h001000, 2'h0});
        fork
            run(8'h20, 24'h001234, 0, 1'b0, 0, 1'b1);
            begin
                tick(100);
                write_latch_set_cmd(1'b0);
                sfpe_host_model_inst.frame(8'h20, 24'h005000, 0, 1'b0, 0);
            end
        join
        tick(20);
        cmp_bit(busy, 1'b0, "refused erase ran");
        cmp_bit(pq.size() == 0 && eq.size() == 0, 1'b1, "writes missing");
        wrap_up;
    end
endmodule // serial_flash_program_erase_tb
